/* srfp_socket_rx_fifo_port.sv */
`timescale 1ns/1ps
// How it works
// - Window writes ignored while memory test off
// - Memory test on: host reads and writes
// - Two-byte reads walk memory in order
// - Sixteen-bit read: earlier byte on top
// - Info header stored before each packet of modes 1-4, except aligned stream
// - Header length fixed by protocol mode
// - Odd packets padded to whole words
// - Sixteen 8 KB blocks, one 128 KB space
// - Transmit/receive split in 8 KB granules
// - Per-socket shares of 0-64 KB, 1 KB steps
// - Zero transmit share forbids transmitting
// - Eight independent sockets, own window and memory
// - Echo requests answered once configured
// - Each 16-bit or high-half window read lowers a nonzero count by two
// - Stream mode with align omits header
module srfp_socket_rx_fifo_port #(
  parameter int NUM_SOCK  = 8,
  parameter int MEM_WORDS = srfp_pkg::MEM_WORDS
) (
  // Clock, reset, enable
  input  wire logic                   ref_clk,
  input  wire logic                   reset_n,
  input  wire logic                   clkEn,
  // Host bus
  input  wire logic [15:0]            hostAddr,
  input  wire logic                   hostCs,
  input  wire logic                   hostRd,
  input  wire logic                   hostWr,
  input  wire logic [15:0]            hostWData,
  output logic      [15:0]            hostRData,
  // Chip mode bits
  input  wire logic                   memTestBit,
  input  wire logic                   busWidthBit,
  // Socket command and mode
  input  wire logic                   cmdStrobe,
  input  wire logic [2:0]             cmdSocket,
  input  wire logic [7:0]             cmdCode,
  input  wire logic [7:0][3:0]        protocolSelect,
  input  wire logic [7:0]             alignBit,
  // Memory allocation
  input  wire logic [4:0]             txTotalBlocks,
  input  wire logic [7:0][6:0]        txShareKb,
  input  wire logic [7:0][6:0]        rxShareKb,
  output logic                        cfgError,
  output logic      [7:0]             txAllowed,
  // Received packet stream from the protocol engine
  input  wire logic                   netStart,
  input  wire logic [2:0]             netSocket,
  input  wire logic [15:0]            netLen,
  input  wire logic [47:0]            netHdrExtra,
  output logic                        netStartReady,
  input  wire logic                   netValid,
  input  wire logic [7:0]             netByte,
  output logic                        netReady,
  // Status and echo service
  output logic      [7:0][16:0]       rxReceivedCount,
  input  wire logic                   netCfgDone,
  input  wire logic                   echoReq,
  output logic                        echoReply
);
  initial begin
    if (NUM_SOCK != 8 || MEM_WORDS != srfp_pkg::MEM_WORDS)
      $error("srfp: only 8 sockets over the full buffer are supported");
  end

  logic [15:0]            mem [MEM_WORDS];
  logic [7:0][15:0]       rdPtr;
  logic [7:0][15:0]       wrPtr;
  logic [7:0][16:0]       usedBytes;
  logic [7:0][16:0]       readSince;
  logic [7:0]             holdLo;
  logic [7:0]             wrHold;
  // Local names for the writer states, so the case reads plainly
  localparam srfp_pkg::srfp_wr_state_t WR_IDLE = srfp_pkg::WR_IDLE;
  localparam srfp_pkg::srfp_wr_state_t WR_HDR  = srfp_pkg::WR_HDR;
  localparam srfp_pkg::srfp_wr_state_t WR_DATA = srfp_pkg::WR_DATA;
  localparam srfp_pkg::srfp_wr_state_t WR_PAD  = srfp_pkg::WR_PAD;
  srfp_pkg::srfp_wr_state_t wrState;
  logic [2:0]             wrSock;
  logic [15:0]            remLen;
  logic [3:0]             hdrIdx;
  logic [3:0]             hdrTot;
  logic [63:0]            hdrBytes;
  logic                   padNeed;
  logic                   pendHalf;
  logic [7:0]             pendByte;

  // Byte offset of a socket's receive share: transmit region first
  function automatic logic [16:0] rxBase(input logic [2:0] s,
                                         input logic [4:0] txb,
                                         input logic [7:0][6:0] kb);
    logic [16:0] acc;
    acc = 17'(txb) * 17'(srfp_pkg::BLOCK_KB * srfp_pkg::KB_BYTES);
    for (int i = 0; i < 8; i++) begin
      if (i < int'(s)) acc = acc + 17'(kb[i]) * 17'(srfp_pkg::KB_BYTES);
    end
    return acc;
  endfunction

  // Pointer advance by one word, wrapping at the share size
  function automatic logic [15:0] nextPtr(input logic [15:0] p,
                                          input logic [6:0] kb);
    logic [16:0] n;
    n = 17'(p) + 17'h00002;
    if (n >= 17'(kb) * 17'(srfp_pkg::KB_BYTES)) n = 17'h00000;
    return n[15:0];
  endfunction

  // Header length of a socket; zero for aligned stream mode
  function automatic logic [3:0] hdrLen(input logic [3:0] mode,
                                        input logic al);
    case (mode)
      srfp_pkg::PROTO_STREAM:   hdrLen = al ? 4'h0 : srfp_pkg::HDR_LEN_STREAM;
      srfp_pkg::PROTO_DATAGRAM: hdrLen = srfp_pkg::HDR_LEN_DATAGRAM;
      srfp_pkg::PROTO_RAW_IP:   hdrLen = srfp_pkg::HDR_LEN_RAW_IP;
      srfp_pkg::PROTO_RAW_ETH:  hdrLen = srfp_pkg::HDR_LEN_RAW_ETH;
      default:                  hdrLen = 4'h0;
    endcase
  endfunction

  // Allocation checks: granule split, share sums, share limits
  logic [16:0] txSumKb, rxSumKb;
  always_comb begin
    txSumKb = 17'h00000;
    rxSumKb = 17'h00000;
    cfgError = 1'b0;
    for (int i = 0; i < 8; i++) begin
      txSumKb = txSumKb + 17'(txShareKb[i]);
      rxSumKb = rxSumKb + 17'(rxShareKb[i]);
      if (txShareKb[i] > 7'(srfp_pkg::MAX_SHARE_KB) ||
          rxShareKb[i] > 7'(srfp_pkg::MAX_SHARE_KB)) cfgError = 1'b1;
      txAllowed[i] = txShareKb[i] != 7'h00;
    end
    if (txTotalBlocks > 5'(srfp_pkg::NUM_BLOCKS)) cfgError = 1'b1;
    if (txSumKb > 17'(txTotalBlocks) * 17'(srfp_pkg::BLOCK_KB)) cfgError = 1'b1;
    if (rxSumKb > 17'(srfp_pkg::TOTAL_KB) -
        17'(txTotalBlocks) * 17'(srfp_pkg::BLOCK_KB)) cfgError = 1'b1;
  end

  // Host window decode; the socket index comes from address bits 8:6
  logic        hit, hiHalf, rdEvt, wrEvt, rdAdvance, hostWordWr;
  logic [2:0]  hostSock;
  logic [15:0] hostWord, memWord;
  assign hit = hostCs && hostAddr[15:9] == srfp_pkg::RX_WIN_PAGE &&
               hostAddr[5:1] == srfp_pkg::RX_WIN_SLOT;
  assign hostSock = hostAddr[8:6];
  assign hiHalf = hostAddr[0];
  assign rdEvt = hit && hostRd;
  assign wrEvt = hit && hostWr && memTestBit;
  assign rdAdvance = rdEvt && (busWidthBit || hiHalf) &&
                     rxReceivedCount[hostSock] != 17'h00000;
  assign hostWordWr = wrEvt && (busWidthBit || hiHalf);
  assign hostWord = busWidthBit ? hostWData : {wrHold, hostWData[7:0]};
  assign memWord = mem[16'((rxBase(hostSock, txTotalBlocks, rxShareKb) +
                             17'(rdPtr[hostSock])) >> 1)];

  // Writer byte stream; a host test write stalls it for the cycle
  logic        byteGo, netWordWr, startFire;
  logic [7:0]  curByte;
  logic [3:0]  startHdr;
  logic [16:0] startNeed, startFree;
  assign byteGo = !wrEvt && (wrState == WR_HDR || wrState == WR_PAD ||
                             (wrState == WR_DATA && netValid));
  assign netReady = wrState == WR_DATA && !wrEvt;
  assign curByte = wrState == WR_HDR  ? hdrBytes[63:56] :
                   wrState == WR_DATA ? netByte : 8'h00;
  assign netWordWr = byteGo && pendHalf;
  assign startHdr = hdrLen(protocolSelect[netSocket], alignBit[netSocket]);
  assign startNeed = 17'(startHdr) + 17'(netLen) + 17'(netLen[0]);
  assign startFree = 17'(rxShareKb[netSocket]) * 17'(srfp_pkg::KB_BYTES) -
                     usedBytes[netSocket];
  assign netStartReady = wrState == WR_IDLE && !cfgError &&
                         startNeed <= startFree;
  assign startFire = netStart && netStartReady && clkEn;

  // Single write port: writer word or host test word, never both
  always_ff @(posedge ref_clk) begin
    if (clkEn && netWordWr)
      mem[16'((rxBase(wrSock, txTotalBlocks, rxShareKb) +
               17'(wrPtr[wrSock])) >> 1)] <= {pendByte, curByte};
    else if (clkEn && hostWordWr)
      mem[16'((rxBase(hostSock, txTotalBlocks, rxShareKb) +
               17'(wrPtr[hostSock])) >> 1)] <= hostWord;
  end

  // Packet writer: header, data, then one pad byte for odd sizes
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      wrState <= WR_IDLE;
      wrSock <= 3'h0;
      remLen <= 16'h0000;
      hdrIdx <= 4'h0;
      hdrTot <= 4'h0;
      hdrBytes <= 64'h0;
      padNeed <= 1'b0;
      pendHalf <= 1'b0;
      pendByte <= 8'h00;
    end else if (clkEn) begin
      if (byteGo) begin
        pendHalf <= !pendHalf;
        pendByte <= curByte;
      end
      case (wrState)
        WR_IDLE: begin
          if (startFire) begin
            wrSock <= netSocket;
            remLen <= netLen;
            padNeed <= netLen[0];
            hdrTot <= startHdr;
            hdrIdx <= 4'h0;
            hdrBytes <= {netLen, netHdrExtra};
            wrState <= startHdr != 4'h0 ? WR_HDR :
                       netLen != 16'h0000 ? WR_DATA : WR_IDLE;
          end
        end
        WR_HDR: begin
          if (byteGo) begin
            hdrIdx <= hdrIdx + 4'h1;
            hdrBytes <= {hdrBytes[55:0], 8'h00};
            if (hdrIdx == hdrTot - 4'h1)
              wrState <= remLen != 16'h0000 ? WR_DATA : WR_IDLE;
          end
        end
        WR_DATA: begin
          if (byteGo) begin
            remLen <= remLen - 16'h0001;
            if (remLen == 16'h0001) wrState <= padNeed ? WR_PAD : WR_IDLE;
          end
        end
        WR_PAD: if (byteGo) wrState <= WR_IDLE;
        default: wrState <= WR_IDLE;
      endcase
    end
  end

  // Read data; 8-bit bus returns the earlier byte on the low half
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      hostRData <= 16'h0000;
      holdLo <= 8'h00;
      wrHold <= 8'h00;
    end else if (clkEn) begin
      if (rdEvt && busWidthBit) hostRData <= memWord;
      else if (rdEvt && !hiHalf) begin
        hostRData <= {8'h00, memWord[15:8]};
        holdLo <= memWord[7:0];
      end else if (rdEvt) hostRData <= {8'h00, holdLo};
      if (wrEvt && !busWidthBit && !hiHalf) wrHold <= hostWData[7:0];
    end
  end

  // Per-socket pointers and counts; a read in the release cycle counts
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < 8; i++) begin
        rdPtr[i] <= srfp_pkg::PTR_RESET;
        wrPtr[i] <= srfp_pkg::PTR_RESET;
        rxReceivedCount[i] <= srfp_pkg::CNT_RESET;
        usedBytes[i] <= srfp_pkg::CNT_RESET;
        readSince[i] <= srfp_pkg::CNT_RESET;
      end
    end else if (clkEn) begin
      for (int i = 0; i < 8; i++) begin
        logic inc, dec, rel;
        inc = (netWordWr && wrSock == 3'(i)) ||
              (hostWordWr && hostSock == 3'(i));
        dec = rdAdvance && hostSock == 3'(i);
        rel = cmdStrobe && cmdSocket == 3'(i) &&
              cmdCode == srfp_pkg::CMD_RECEIVE_DONE;
        if (inc) wrPtr[i] <= nextPtr(wrPtr[i], rxShareKb[i]);
        if (dec) rdPtr[i] <= nextPtr(rdPtr[i], rxShareKb[i]);
        rxReceivedCount[i] <= rxReceivedCount[i] + (inc ? 17'h2 : 17'h0) -
                              (dec ? 17'h2 : 17'h0);
        usedBytes[i] <= usedBytes[i] + (inc ? 17'h2 : 17'h0) -
                        (rel ? readSince[i] : 17'h0);
        readSince[i] <= (rel ? 17'h0 : readSince[i]) +
                        (dec ? 17'h2 : 17'h0);
      end
    end
  end

  // Echo service runs without the host once set up
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) echoReply <= 1'b0;
    else if (clkEn) echoReply <= echoReq && netCfgDone && !cfgError;
  end

  // Helper samples for the checks below
  logic [2:0]  sockQ;
  logic [16:0] cntQ, usedQ, sinceQ;
  logic [15:0] wrPtrQ;
  always_ff @(posedge ref_clk) begin
    sockQ <= cmdStrobe ? cmdSocket : hostSock;
    cntQ <= rxReceivedCount[hostSock];
    wrPtrQ <= wrPtr[hostSock];
    usedQ <= usedBytes[cmdSocket];
    sinceQ <= readSince[cmdSocket];
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  sequence lowHalfRead;
    clkEn && rdEvt && !busWidthBit && !hiHalf;
  endsequence
  sequence highHalfRead;
    clkEn && rdEvt && !busWidthBit && hiHalf;
  endsequence

  read_decrement_a: assert property (clkEn && rdAdvance && !cmdStrobe &&
    !(netWordWr && wrSock == hostSock) |=> rxReceivedCount[sockQ] == cntQ - 17'h2)
    else $error("window read did not lower count by two");
  write_blocked_a: assert property (clkEn && hit && hostWr && !memTestBit &&
    !cmdStrobe && wrState == srfp_pkg::WR_IDLE |=> wrPtr[sockQ] == wrPtrQ)
    else $error("host write accepted with memory test off");
  write_allowed_a: assert property (clkEn && hostWordWr && !cmdStrobe |=>
    rxReceivedCount[sockQ] == cntQ + 17'h2)
    else $error("memory test write not stored");
  word_order_a: assert property (clkEn && rdAdvance && busWidthBit |=>
    hostRData == $past(memWord))
    else $error("16-bit read byte order wrong");
  // The host leaves one idle cycle between the two halves of a pair
  byte_pair_a: assert property (lowHalfRead ##1 !(clkEn && rdEvt) ##1
    highHalfRead |=> hostRData == ($past(memWord, 3) & 16'h00ff))
    else $error("high half did not return the following byte");
  header_len_a: assert property (startFire && startHdr != 4'h0 |=>
    wrState == srfp_pkg::WR_HDR && hdrTot == $past(startHdr))
    else $error("header length not taken from mode");
  align_skip_a: assert property (startFire && startHdr == 4'h0 &&
    netLen != 16'h0000 |=> wrState == srfp_pkg::WR_DATA)
    else $error("aligned stream wrote a header");
  odd_pad_a: assert property (clkEn && byteGo && wrState == srfp_pkg::WR_DATA &&
    remLen == 16'h0001 && padNeed |=> wrState == srfp_pkg::WR_PAD ##1
    (!clkEn || wrEvt || wrState == srfp_pkg::WR_IDLE))
    else $error("odd packet not padded by one byte");
  receive_done_command_release_a: assert property (clkEn && cmdStrobe &&
    cmdCode == srfp_pkg::CMD_RECEIVE_DONE && !hostWordWr && !netWordWr |=>
    usedBytes[sockQ] == usedQ - sinceQ)
    else $error("receive-done did not free read space");
  echo_reply_a: assert property (clkEn && echoReq && netCfgDone && !cfgError
    |=> echoReply)
    else $error("echo request left unanswered");
endmodule

/* srfp_pkg.sv */
package srfp_pkg;
  // Host window decode: page holds bits 15:9, word slot bits 5:1
  localparam logic [15:0] RX_WIN_OFS   = 16'h8230;
  localparam logic [15:0] SOCK_STRIDE  = 16'h0040;
  localparam logic [6:0]  RX_WIN_PAGE  = RX_WIN_OFS[15:9];
  localparam logic [4:0]  RX_WIN_SLOT  = RX_WIN_OFS[5:1];
  // Socket command code that hands read space back
  localparam logic [7:0]  CMD_RECEIVE_DONE = 8'h40;
  // Protocol select codes
  localparam logic [3:0]  PROTO_STREAM   = 4'h1;
  localparam logic [3:0]  PROTO_DATAGRAM = 4'h2;
  localparam logic [3:0]  PROTO_RAW_IP   = 4'h3;
  localparam logic [3:0]  PROTO_RAW_ETH  = 4'h4;
  // Header lengths in bytes per mode
  localparam logic [3:0]  HDR_LEN_STREAM   = 4'h2;
  localparam logic [3:0]  HDR_LEN_DATAGRAM = 4'h8;
  localparam logic [3:0]  HDR_LEN_RAW_IP   = 4'h6;
  localparam logic [3:0]  HDR_LEN_RAW_ETH  = 4'h2;
  // Buffer geometry
  localparam int          NUM_BLOCKS   = 16;
  localparam int          BLOCK_KB     = 8;
  localparam int          KB_BYTES     = 1024;
  localparam int          MAX_SHARE_KB = 64;
  localparam int          TOTAL_KB     = NUM_BLOCKS * BLOCK_KB;
  localparam int          MEM_WORDS    = TOTAL_KB * KB_BYTES / 2;
  // Reset values
  localparam logic [15:0] PTR_RESET = 16'h0000;
  localparam logic [16:0] CNT_RESET = 17'h00000;
  typedef enum logic [1:0] {WR_IDLE, WR_HDR, WR_DATA, WR_PAD} srfp_wr_state_t;
endpackage

/* srfp_host_model.sv */
`timescale 1ns/1ps
module srfp_host_model (
  // Clock
  input  wire logic        ref_clk,
  // Host bus
  output logic      [15:0] hostAddr,
  output logic             hostCs,
  output logic             hostRd,
  output logic             hostWr,
  output logic      [15:0] hostWData,
  input  wire logic [15:0] hostRData,
  // Chip mode bits and socket command
  output logic             memTestBit,
  output logic             busWidthBit,
  output logic             cmdStrobe,
  output logic      [2:0]  cmdSocket,
  output logic      [7:0]  cmdCode
);
  // Idle bus; memory test starts off, bus is 16 bits wide
  initial begin
    {hostAddr, hostCs, hostRd, hostWr, hostWData} = '0;
    {memTestBit, cmdStrobe, cmdSocket, cmdCode} = '0;
    busWidthBit = 1'b1;
  end

  // One access, held until the taking edge; released data is inverted
  // so a stale value can never pass for a fresh one
  task automatic access(input logic [15:0] a, input logic wr,
                        input logic [15:0] d, output logic [15:0] q);
    hostAddr = a;
    hostCs = 1'b1;
    hostRd = !wr;
    hostWr = wr;
    hostWData = d;
    @(posedge ref_clk);
    #1;
    q = hostRData;
    {hostCs, hostRd, hostWr} = 3'h0;
    hostWData = ~d;
    @(posedge ref_clk);
    #1;
  endtask

  // Window address of a socket; transmit port never touched
  function automatic logic [15:0] win(input logic [2:0] s);
    return srfp_pkg::RX_WIN_OFS + {7'h00, s, 6'h00};
  endfunction

  task automatic rdWord(input logic [2:0] s, output logic [15:0] q);
    access(win(s), 1'b0, 16'h0000, q);
  endtask

  // Eight-bit bus: low half then high half, always as a pair
  task automatic rdPair(input logic [2:0] s, output logic [15:0] q);
    logic [15:0] lo, hi;
    access(win(s), 1'b0, 16'h0000, lo);
    access(win(s) | 16'h0001, 1'b0, 16'h0000, hi);
    q = {lo[7:0], hi[7:0]};
  endtask

  task automatic wrWord(input logic [2:0] s, input logic [15:0] d);
    logic [15:0] q;
    access(win(s), 1'b1, d, q);
  endtask

  // Memory test bit is cleared again by the caller after
  task automatic setMode(input logic mt, input logic bw);
    memTestBit = mt;
    busWidthBit = bw;
  endtask

  // Receive done only after the data was read out
  task automatic recvDone(input logic [2:0] s);
    cmdSocket = s;
    cmdCode = srfp_pkg::CMD_RECEIVE_DONE;
    cmdStrobe = 1'b1;
    @(posedge ref_clk);
    #1;
    cmdStrobe = 1'b0;
  endtask
endmodule

/* srfp_socket_rx_fifo_port_bench.sv */
`timescale 1ns/1ps
module srfp_socket_rx_fifo_port_bench;
  // Clock, reset and engine-side stimulus
  logic              ref_clk = 1'b0;
  logic              reset_n = 1'b0;
  logic              clkEn = 1'b1;
  logic [15:0]       hostAddr, hostWData, hostRData, q;
  logic              hostCs, hostRd, hostWr, memTestBit, busWidthBit;
  logic              cmdStrobe, cfgError, netStartReady, netReady, echoReply;
  logic [2:0]        cmdSocket;
  logic [7:0]        cmdCode, txAllowed;
  logic [7:0][3:0]   protocolSelect = {4'h1, 4'h0, 4'h1, 4'h4, 4'h3,
                                       4'h1, 4'h2, 4'h1};
  logic [7:0]        alignBit = 8'h20;
  logic [4:0]        txTotalBlocks = 5'h09;
  logic [7:0][6:0]   txShareKb = {7'd12, 7'd12, 7'd7, 7'd0, 7'd20, 7'd1,
                                  7'd16, 7'd4};
  logic [7:0][6:0]   rxShareKb = {7'd4, 7'd4, 7'd4, 7'd3, 7'd16, 7'd5,
                                  7'd3, 7'd17};
  logic              netStart = 1'b0;
  logic              netValid = 1'b0;
  logic              netCfgDone = 1'b0;
  logic              echoReq = 1'b0;
  logic [2:0]        netSocket = 3'h0;
  logic [15:0]       netLen = 16'h0000;
  logic [47:0]       netHdrExtra = 48'h0a0b0c0d0e0f;
  logic [7:0]        netByte = 8'h00;
  logic [7:0][16:0]  rxReceivedCount;
  int                numErrors = 0;
  int                checked = 0;

  always #2.5 ref_clk = ~ref_clk;

  srfp_socket_rx_fifo_port srfp_socket_rx_fifo_port_inst (.*);
  srfp_host_model srfp_host_model_inst (.ref_clk(ref_clk),
    .hostAddr(hostAddr), .hostCs(hostCs), .hostRd(hostRd), .hostWr(hostWr),
    .hostWData(hostWData), .hostRData(hostRData), .memTestBit(memTestBit),
    .busWidthBit(busWidthBit), .cmdStrobe(cmdStrobe),
    .cmdSocket(cmdSocket), .cmdCode(cmdCode));

  // Compare tasks: stored data and counts, then flags
  task automatic chkData(input logic [16:0] got, input logic [16:0] exp);
    checked++;
    if (got !== exp) begin
      numErrors++;
      $display("unexpected data at %0t: got %h not %h", $time, got, exp);
    end
  endtask
  task automatic chkFlag(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      numErrors++;
      $display("unexpected flag at %0t: got %h not %h", $time, got, exp);
    end
  endtask

  task automatic giveVerdict();
    $display("comparisons %0d mismatches %0d", checked, numErrors);
    if (numErrors == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Bounded wait on start-ready or data-ready
  task automatic waitReady(input bit data);
    int n = 0;
    while ((data ? netReady : netStartReady) !== 1'b1 && n < 200) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    if (n >= 200) begin
      numErrors++;
      $display("unexpected hang at %0t: ready stayed low", $time);
      giveVerdict();
    end
  endtask

  // One packet of len bytes 60h, 61h, ...; returns once writer is idle
  task automatic sendPkt(input logic [2:0] s, input logic [15:0] len);
    waitReady(1'b0);
    netSocket = s;
    netLen = len;
    netStart = 1'b1;
    @(posedge ref_clk);
    #1;
    netStart = 1'b0;
    for (int i = 0; i < len; i++) begin
      waitReady(1'b1);
      netValid = 1'b1;
      netByte = 8'h60 + 8'(i);
      @(posedge ref_clk);
      #1;
    end
    netValid = 1'b0;
    waitReady(1'b0);
  endtask

  initial begin
    logic [15:0] expA [3] = '{16'h0003, 16'h6061, 16'h6200};
    logic [15:0] expB [5] = '{16'h0002, 16'h0a0b, 16'h0c0d, 16'h0e0f,
                              16'h6061};
    logic [16:0] expC [4] = '{17'd8, 17'd4, 17'd2, 17'd2};
    repeat (12) @(posedge ref_clk);
    chkData({1'b0, hostRData}, 17'h00000);
    chkData(rxReceivedCount[0], 17'h00000);
    #1;
    reset_n = 1'b1;
    // Allocation: zero tx share blocks sending, limits flagged
    chkFlag(txAllowed, 8'hef);
    chkFlag({7'h00, cfgError}, 8'h00);
    rxShareKb[0] = 7'd65;
    #1 chkFlag({7'h00, cfgError}, 8'h01);
    rxShareKb[0] = 7'd17;
    txTotalBlocks = 5'h11;
    #1 chkFlag({7'h00, cfgError}, 8'h01);
    txTotalBlocks = 5'h09;
    @(posedge ref_clk);
    #1;
    // Stream packet, odd length, read on the 16-bit bus
    sendPkt(3'd0, 16'd3);
    chkData(rxReceivedCount[0], 17'd6);
    foreach (expA[i]) begin
      srfp_host_model_inst.rdWord(3'd0, q);
      chkData({1'b0, q}, {1'b0, expA[i]});
      chkData(rxReceivedCount[0], 17'(4 - 2 * i));
    end
    srfp_host_model_inst.rdWord(3'd0, q);
    chkData(rxReceivedCount[0], 17'd0);
    srfp_host_model_inst.recvDone(3'd0);
    chkFlag({7'h00, netStartReady}, 8'h01);
    // Datagram packet read in pairs on the 8-bit bus
    srfp_host_model_inst.setMode(1'b0, 1'b0);
    sendPkt(3'd1, 16'd2);
    chkData(rxReceivedCount[1], 17'd10);
    foreach (expB[i]) begin
      srfp_host_model_inst.rdPair(3'd1, q);
      chkData({1'b0, q}, {1'b0, expB[i]});
    end
    chkData(rxReceivedCount[1], 17'd0);
    // Raw IP, raw Ethernet, aligned stream and headerless sockets
    srfp_host_model_inst.setMode(1'b0, 1'b1);
    for (int s = 3; s < 7; s++) begin
      sendPkt(3'(s), 16'd2);
    end
    foreach (expC[i]) begin
      chkData(rxReceivedCount[i + 3], expC[i]);
    end
    chkData(rxReceivedCount[0], 17'd0);
    srfp_host_model_inst.rdWord(3'd5, q);
    chkData({1'b0, q}, 17'h06061);
    // Window writes only with the memory test bit set
    srfp_host_model_inst.wrWord(3'd2, 16'h5555);
    chkData(rxReceivedCount[2], 17'd0);
    srfp_host_model_inst.setMode(1'b1, 1'b1);
    srfp_host_model_inst.wrWord(3'd2, 16'h1234);
    chkData(rxReceivedCount[2], 17'd2);
    srfp_host_model_inst.rdWord(3'd2, q);
    chkData({1'b0, q}, 17'h01234);
    srfp_host_model_inst.setMode(1'b0, 1'b1);
    // Echo reply only once configured
    for (int c = 0; c < 2; c++) begin
      netCfgDone = c[0];
      echoReq = 1'b1;
      @(posedge ref_clk);
      #1;
      echoReq = 1'b0;
      chkFlag({7'h00, echoReply}, {7'h00, c[0]});
      @(posedge ref_clk);
      #1;
      chkFlag({7'h00, echoReply}, 8'h00);
    end
    giveVerdict();
  end
endmodule
